//--- rtl/strobe_defines.svh
`ifndef STROBE_DEFINES_SVH
`define STROBE_DEFINES_SVH
// oscillator periods per machine cycle
`define OSC_PER_CYCLE_STD   4'hC
`define OSC_PER_CYCLE_X2    4'h6
// phase positions inside a machine cycle, one step per oscillator clock
`define PHASE_ALE_A         4'h1
`define PHASE_ALE_B         4'h7
`define PHASE_FETCH_A_START 4'h3
`define PHASE_FETCH_A_END   4'h5
`define PHASE_FETCH_B_START 4'h9
`define PHASE_FETCH_B_END   4'hB
`define PHASE_LAST          4'hB
// double speed visits only the odd phase positions
`define PHASE_FIRST_X2      4'h1
`define PHASE_STEP_X2       4'h2
`define RESET_CYCLES        2'h2
`define SKIP_PER_DATA       2'h2
`endif

//--- rtl/strobe_pkg.sv
package strobe_pkg;
  typedef enum logic [2:0] {
    st_run     = 3'b001,
    st_data    = 3'b010,
    st_reset   = 3'b100
  } bus_state_t;
endpackage

//--- rtl/phase_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "strobe_defines.svh"
module phase_divider (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_double_speed_mode,
  output logic            o_tick,
  output logic [3:0]      o_phase,
  output logic            o_cycle_end
);
  logic [3:0] phase;
  logic       run;
  logic [3:0] next_phase;
  logic       next_run;

  // one phase step per clock; double speed jumps over the even steps
  always_comb begin
    next_run   = 1'b1;
    next_phase = phase;
    if (run) begin
      if (phase == `PHASE_LAST) begin
        next_phase = i_double_speed_mode ? `PHASE_FIRST_X2 : 4'h0;
      end else if (i_double_speed_mode && phase[0]) begin
        next_phase = phase + `PHASE_STEP_X2;
      end else begin
        next_phase = phase + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase <= 4'h0;
      run   <= 1'b0;
    end else begin
      phase <= next_phase;
      run   <= next_run;
    end
  end

  assign o_tick      = run;
  assign o_phase     = phase;
  assign o_cycle_end = run & (phase == `PHASE_LAST);
endmodule
`default_nettype wire

//--- rtl/external_memory_strobe_control.sv
// Behaviour
// RULE1: latch strobe at osc/6, osc/3 double speed
// RULE2: no latch strobe during external data access; the code keeps the first pulse, carrying the data address
// RULE3: software may disable latch strobe internally
// RULE4: latch strobe marks valid low address
// RULE5: fetch strobe twice per external fetch cycle
// RULE6: skip two fetch strobes per data access
// RULE7: fetch strobe idle for internal fetches
// RULE8: select pin high internal, low external
// RULE9: reset after two machine cycles high
// RULE10: ports switch to address/data during bus cycles
// RULE11: write strobe latches low-port data byte
// RULE12: machine cycle twelve or six oscillator periods
// RULE13: fetch strobe active low, else high
`timescale 1ns/100ps
`default_nettype none
`include "strobe_defines.svh"
module external_memory_strobe_control
  import strobe_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_reset_pin,
  input  wire logic       i_external_fetch_select,
  input  wire logic       i_double_speed_mode,
  input  wire logic       i_ale_disable,
  input  wire logic       i_data_access_req,
  input  wire logic       i_data_write,
  input  wire logic [15:0] i_fetch_address,
  input  wire logic [15:0] i_data_address,
  input  wire logic [7:0] i_write_data,
  input  wire logic [7:0] i_port0_latch,
  input  wire logic [7:0] i_port2_latch,
  output logic            o_address_latch_strobe,
  output logic            o_program_fetch_strobe_n,
  output logic            o_data_write_strobe_n,
  output logic            o_data_read_strobe_n,
  output logic            o_fetch_external,
  output logic            o_core_reset,
  output logic            o_data_access_done,
  output logic [7:0]      o_port0_out,
  output logic [7:0]      o_port0_oe_n,
  output logic [7:0]      o_port2_out
);
  logic       tick;
  logic [3:0] phase;
  logic       cycle_end;

  phase_divider u_div (
    .i_clk               (i_clk),
    .i_srst              (i_srst),
    .i_double_speed_mode (i_double_speed_mode),
    .o_tick              (tick),
    .o_phase             (phase),
    .o_cycle_end         (cycle_end)
  ); // see RULE12

  // two-flop synchronisers for the asynchronous pins
  logic       rst_meta;
  logic       rst_sync;
  logic       sel_meta;
  logic       sel_sync;
  always_ff @(posedge i_clk) begin
    rst_meta <= i_reset_pin;
    rst_sync <= rst_meta;
    sel_meta <= i_external_fetch_select;
    sel_sync <= sel_meta;
  end

  bus_state_t state;
  bus_state_t next_state;
  logic [1:0] rst_cnt;
  logic [1:0] next_rst_cnt;
  logic       ext_fetch;
  logic       next_ext_fetch;
  logic       ale;
  logic       next_ale;
  logic       program_fetch_strobe_n;
  logic       next_program_fetch_strobe_n;
  logic       wr_n;
  logic       next_wr_n;
  logic       rd_n;
  logic       next_rd_n;
  logic       done;
  logic       next_done;
  logic       is_write;
  logic       next_is_write;
  logic [7:0] p0;
  logic [7:0] next_p0;
  logic [7:0] p0_oe_n;
  logic [7:0] next_p0_oe_n;
  logic [7:0] p2;
  logic [7:0] next_p2;
  logic       fetch_win;
  logic       ale_phase;
  logic       ale_allowed;

  assign fetch_win = (phase >= `PHASE_FETCH_A_START && phase < `PHASE_FETCH_A_END) ||
                     (phase >= `PHASE_FETCH_B_START && phase < `PHASE_FETCH_B_END);
  assign ale_phase = (phase == `PHASE_ALE_A) || (phase == `PHASE_ALE_B);
  // software may silence the latch strobe only while fetching internally
  assign ale_allowed = ~(i_ale_disable & ~ext_fetch); // see RULE3

  always_comb begin
    next_state    = state;
    next_rst_cnt  = rst_cnt;
    next_ext_fetch = ext_fetch;
    next_ale      = ale;
    next_program_fetch_strobe_n   = program_fetch_strobe_n;
    next_wr_n     = wr_n;
    next_rd_n     = rd_n;
    next_done     = 1'b0;
    next_is_write = is_write;
    next_p0       = p0;
    next_p0_oe_n  = p0_oe_n;
    next_p2       = p2;
    if (cycle_end) begin
      if (!rst_sync) begin
        next_rst_cnt = 2'h0;
      end else if (rst_cnt != `RESET_CYCLES) begin
        next_rst_cnt = rst_cnt + 2'h1; // see RULE9
      end
      next_ext_fetch = ~sel_sync; // see RULE8
    end
    if (tick) begin
      case (state)
        st_run: begin
          next_ale    = ale_phase & ale_allowed; // see RULE1
          next_program_fetch_strobe_n = ~(ext_fetch & fetch_win); // see RULE5
          if (ale_phase) begin
            next_p0      = ext_fetch ? i_fetch_address[7:0] : i_port0_latch; // see RULE4
            next_p2      = ext_fetch ? i_fetch_address[15:8] : i_port2_latch; // see RULE10
            next_p0_oe_n = ext_fetch ? 8'h00 : ~i_port0_latch;
          end else if (ext_fetch && fetch_win) begin
            next_p0_oe_n = 8'hFF;
          end
          if (cycle_end && i_data_access_req) begin
            next_state    = st_data;
            next_is_write = i_data_write;
            next_p0       = i_data_address[7:0]; // see RULE4
            next_p2       = i_data_address[15:8]; // see RULE10
            next_p0_oe_n  = 8'h00;
          end
        end
        st_data: begin
          // only the first latch pulse is kept, carrying the data address
          next_ale    = (phase == `PHASE_ALE_A) & ale_allowed; // see RULE2
          next_program_fetch_strobe_n = 1'b1; // see RULE6
          if (phase == `PHASE_FETCH_A_START) begin
            next_wr_n    = ~is_write; // see RULE11
            next_rd_n    = is_write;
            next_p0      = is_write ? i_write_data : next_p0;
            next_p0_oe_n = is_write ? 8'h00 : 8'hFF;
          end
          if (phase == `PHASE_FETCH_B_END) begin
            next_wr_n = 1'b1;
            next_rd_n = 1'b1;
          end
          if (cycle_end) begin
            next_state   = st_run;
            next_done    = 1'b1;
            next_p0_oe_n = ~i_port0_latch;
          end
        end
        st_reset: next_state = st_run;
        default:  next_state = st_run;
      endcase
    end
    if (!ext_fetch && state == st_run) begin
      next_program_fetch_strobe_n = 1'b1; // see RULE7
    end
    // a pin reset holds every strobe idle until the pin is released
    if (rst_cnt == `RESET_CYCLES) begin
      next_state  = st_reset;
      next_ale    = 1'b0;
      next_program_fetch_strobe_n = 1'b1; // see RULE13
      next_wr_n   = 1'b1;
      next_rd_n   = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state     <= st_reset;
      rst_cnt   <= 2'h0;
      ext_fetch <= 1'b0;
      ale       <= 1'b0;
      program_fetch_strobe_n    <= 1'b1;
      wr_n      <= 1'b1;
      rd_n      <= 1'b1;
      done      <= 1'b0;
      is_write  <= 1'b0;
      p0        <= 8'hFF;
      p0_oe_n   <= 8'hFF;
      p2        <= 8'hFF;
    end else begin
      state     <= next_state;
      rst_cnt   <= next_rst_cnt;
      ext_fetch <= next_ext_fetch;
      ale       <= next_ale;
      program_fetch_strobe_n    <= next_program_fetch_strobe_n;
      wr_n      <= next_wr_n;
      rd_n      <= next_rd_n;
      done      <= next_done;
      is_write  <= next_is_write;
      p0        <= next_p0;
      p0_oe_n   <= next_p0_oe_n;
      p2        <= next_p2;
    end
  end

  assign o_address_latch_strobe   = ale;
  assign o_program_fetch_strobe_n = program_fetch_strobe_n;
  assign o_data_write_strobe_n    = wr_n;
  assign o_data_read_strobe_n     = rd_n;
  assign o_fetch_external         = ext_fetch;
  assign o_core_reset             = (state == st_reset);
  assign o_data_access_done       = done;
  assign o_port0_out              = p0;
  assign o_port0_oe_n             = p0_oe_n;
  assign o_port2_out              = p2;
endmodule
`default_nettype wire

//--- verif/strobe_checker.sv
`timescale 1ns/100ps
`default_nettype none
module strobe_checker (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_double_speed_mode,
  input wire logic       i_external_fetch_select,
  input wire logic       o_address_latch_strobe,
  input wire logic       o_program_fetch_strobe_n,
  input wire logic       o_data_write_strobe_n,
  input wire logic       o_data_read_strobe_n,
  input wire logic       o_fetch_external,
  input wire logic [7:0] o_port0_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_ale_std; $rose(o_address_latch_strobe) && !i_double_speed_mode |=> (!$rose(o_address_latch_strobe))[*5]; endproperty
  property p_ale_x2; $rose(o_address_latch_strobe) && i_double_speed_mode |=> (!$rose(o_address_latch_strobe))[*2]; endproperty
  property p_rst_idle; $fell(i_srst) |-> !o_address_latch_strobe && o_program_fetch_strobe_n && o_data_write_strobe_n; endproperty
  property p_int_idle; (!o_fetch_external)[*4] |-> o_program_fetch_strobe_n; endproperty
  property p_fetch_ext; $fell(o_program_fetch_strobe_n) |-> o_fetch_external; endproperty
  property p_wr_quiet; !o_data_write_strobe_n || !o_data_read_strobe_n |-> o_program_fetch_strobe_n && !o_address_latch_strobe; endproperty
  property p_wr_drive; !o_data_write_strobe_n |-> o_port0_oe_n == 8'h00; endproperty
  property p_sel; $fell(i_external_fetch_select) |-> ##[1:40] o_fetch_external; endproperty
  a_ale_std: assert property (p_ale_std) else $error("latch strobe period short");
  a_ale_x2: assert property (p_ale_x2) else $error("latch strobe period short x2");
  a_rst_idle: assert property (p_rst_idle) else $error("strobes active after reset");
  a_int_idle: assert property (p_int_idle) else $error("fetch strobe on internal fetch");
  a_fetch_ext: assert property (p_fetch_ext) else $error("fetch strobe not external");
  a_wr_quiet: assert property (p_wr_quiet) else $error("strobe during data access");
  a_wr_drive: assert property (p_wr_drive) else $error("port0 not driven on write");
  a_sel: assert property (p_sel) else $error("external fetch not selected");
  c_ale: cover property ($rose(o_address_latch_strobe));
  c_wr: cover property ($fell(o_data_write_strobe_n));
  c_rd: cover property ($fell(o_data_read_strobe_n));
endmodule
bind external_memory_strobe_control strobe_checker i_strobe_checker (.i_clk, .i_srst, .i_double_speed_mode,
  .i_external_fetch_select, .o_address_latch_strobe, .o_program_fetch_strobe_n, .o_data_write_strobe_n,
  .o_data_read_strobe_n, .o_fetch_external, .o_port0_oe_n);
`default_nettype wire

//--- verif/ext_address_latch.sv
`timescale 1ns/100ps
`default_nettype none
module ext_address_latch (
  input  wire logic       i_clk,
  input  wire logic       i_strobe,
  input  wire logic [7:0] i_bus,
  output logic [7:0]      o_low
);
  // low byte loaded on each clock while the strobe is high, kept after it falls
  always_ff @(posedge i_clk) begin
    if (i_strobe) o_low <= i_bus;
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic i_clk = 0, i_srst = 1, i_reset_pin = 0, i_external_fetch_select = 1, i_double_speed_mode = 0;
  logic i_ale_disable = 0, i_data_access_req = 0, i_data_write = 0;
  logic ale, program_fetch_strobe_n, wr_n, rd_n, fetch_ext, core_rst, done, ale_q = 0, program_fetch_strobe_q = 1, wr_q = 1, rd_q = 1;
  logic [7:0] p0, p2, low;
  int err_total = 0, comparisons = 0, cyc = 0, n_ale = 0, n_program_fetch_strobe = 0, n_wr = 0, n_rd = 0;
  always #12.5 i_clk = ~i_clk;
  external_memory_strobe_control i_external_memory_strobe_control (.i_clk, .i_srst, .i_reset_pin,
    .i_external_fetch_select, .i_double_speed_mode, .i_ale_disable, .i_data_access_req, .i_data_write,
    .i_fetch_address(16'h12A5), .i_data_address(16'h3C5A), .i_write_data(8'h96), .i_port0_latch(8'hFF),
    .i_port2_latch(8'hFF), .o_address_latch_strobe(ale), .o_program_fetch_strobe_n(program_fetch_strobe_n),
    .o_data_write_strobe_n(wr_n), .o_data_read_strobe_n(rd_n), .o_fetch_external(fetch_ext),
    .o_core_reset(core_rst), .o_data_access_done(done), .o_port0_out(p0), .o_port0_oe_n(), .o_port2_out(p2));
  ext_address_latch i_ext_address_latch (.i_clk, .i_strobe(ale), .i_bus(p0), .o_low(low));
  always @(posedge i_clk) begin
    ale_q <= ale;
    program_fetch_strobe_q <= program_fetch_strobe_n;
    wr_q <= wr_n;
    rd_q <= rd_n;
    cyc <= cyc + 1;
    if (ale && !ale_q) n_ale <= n_ale + 1;
    if (!program_fetch_strobe_n && program_fetch_strobe_q) n_program_fetch_strobe <= n_program_fetch_strobe + 1;
    if (!wr_n && wr_q) n_wr <= n_wr + 1;
    if (!rd_n && rd_q) n_rd <= n_rd + 1;
    if (cyc == 3000) begin err_total++; wrap_up; end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin err_total++; $display("MISMATCH %0t %s got %h want %h", $time, what, seen, exp); end
  endtask
  task automatic go(input logic x2, input logic sel, input logic dis);
    i_srst <= 1; i_double_speed_mode <= x2; i_external_fetch_select <= sel; i_ale_disable <= dis;
    repeat (5) @(posedge i_clk);
    i_srst <= 0;
    repeat (40) @(posedge i_clk);
  endtask
  task automatic measure(input logic x2, input logic sel, input logic dis, input logic [15:0] ea, input logic [15:0] ep);
    int a, b;
    go(x2, sel, dis);
    a = n_ale; b = n_program_fetch_strobe;
    repeat (x2 ? 12 : 24) @(posedge i_clk);
    chk(16'(n_ale - a), ea, "latch strobes");
    chk(16'(n_program_fetch_strobe - b), ep, "fetch strobes");
    chk(16'(fetch_ext), 16'(!sel), "fetch select");
  endtask
  task automatic t_external;
    measure(0, 0, 0, 4, 4); measure(1, 0, 0, 4, 4); measure(0, 0, 1, 4, 4);
    chk({8'h00, low}, 16'h00A5, "latched low byte");
    $display("test external done");
  endtask
  task automatic t_internal;
    measure(0, 1, 0, 4, 0);
    measure(0, 1, 1, 0, 0);
    i_external_fetch_select <= 0;
    repeat (30) @(posedge i_clk);
    chk(16'(fetch_ext), 16'h0001, "select fell in run");
    $display("test internal done");
  endtask
  task automatic t_data(input logic wr);
    int a, b, w, r, nd;
    go(0, 0, 0);
    a = n_ale;
    b = n_program_fetch_strobe;
    w = n_wr;
    r = n_rd;
    nd = 0;
    i_data_access_req <= 1;
    i_data_write <= wr;
    for (int k = 0; k < 48; k++) begin
      @(posedge i_clk);
      if (done === 1'b1) begin
        nd++;
        i_data_access_req <= 0;
        chk({8'h00, low}, 16'h005A, "data address latched");
        chk({8'h00, p2}, 16'h003C, "data address high");
      end
    end
    chk(16'(nd), 16'h0001, "done pulses");
    chk(16'(n_program_fetch_strobe - b), 16'h0006, "fetch strobes skipped");
    chk(16'(n_ale - a), 16'h0007, "latch strobes omitted");
    chk(16'(n_wr - w), 16'(wr), "write strobes");
    chk(16'(n_rd - r), 16'(!wr), "read strobes");
    $display("test data %0d done", wr);
  endtask
  task automatic t_pin_reset;
    go(0, 1, 0);
    i_reset_pin <= 1; repeat (8) @(posedge i_clk); i_reset_pin <= 0; repeat (30) @(posedge i_clk);
    chk(16'(core_rst), 16'h0000, "short pin pulse");
    i_reset_pin <= 1; repeat (60) @(posedge i_clk);
    chk(16'(core_rst), 16'h0001, "pin reset");
    i_reset_pin <= 0; repeat (60) @(posedge i_clk);
    chk(16'(core_rst), 16'h0000, "pin reset released");
    $display("test pin reset done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_external; t_internal; t_data(1); t_data(0); t_pin_reset;
    wrap_up;
  end
endmodule
`default_nettype wire
